// ===== rtl/flash_cmd_device.sv
// Purpose: status register, write-enable latch and upper address byte command handling
// Assumes: link pins asynchronous to clk; sclk at most clk/8
// Notes: array read, program and erase sit outside and talk through the side ports
//
// Added by the designer: the Avalon-MM slave port and the register offsets.
`timescale 1ns/100ps
// Functional notes
// R1 - write enable code sets latch
// R2 - latch required before any modifying operation
// R3 - volatile enable leaves latch, arms next write
// R4 - write disable clears latch
// R5 - latch cleared at reset and completions
// R6 - read status codes shift MSB first
// R7 - status reads allowed while busy
// R8 - status byte repeats until select rises
// R9 - only writable fields change
// R10 - security lock bits never return to zero
// R11 - nonvolatile write needs latch, code, data
// R12 - volatile write keeps latch and OTP bits
// R13 - reset reloads volatile from nonvolatile copies
// R14 - nonvolatile write busy, then clears latch
// R15 - volatile write applies promptly, busy stays zero
// R16 - quad enable frozen in four-line mode
// R17 - code 01h writes one or two registers
// R18 - upper byte readable, used in 3-byte mode
// R19 - 4-byte commands overwrite upper byte
// R20 - upper byte write needs latch
// R21 - upper byte cleared at any reset
// R22 - host rechecks upper byte on mode exit
// R23 - enter code selects 32-bit addressing
// R24 - writes without latch are ignored
module flash_cmd_device
    import flash_cmd_pkg::*;
#(
    parameter int NV_CYCLES = NV_WRITE_CYCLES,
    parameter logic [7:0] SR1_INIT = SR_RESET,
    parameter logic [7:0] SR2_INIT = SR_RESET,
    parameter logic [7:0] SR3_INIT = SR_RESET
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // serial link
    flash_link_if.device link,
    // rest of device
    input wire logic deviceReset,
    input wire logic arrayBusy,
    input wire logic programDone,
    input wire logic fourLineCommandMode,
    input wire logic addrTopValid,
    input wire logic [7:0] addrTopByte,
    output logic writeEnableLatch,
    output logic busy,
    output logic addressSizeFlag,
    output logic [7:0] upperAddressByte,
    output logic quadEnable
);
    // ------------------------------------------------------------
    // pin synchronisers and edges
    // ------------------------------------------------------------
    logic [1:0] csSync, sclkSync, mosiSync;
    logic csLast, sclkLast;
    always_ff @(posedge clk) begin
        if (rst) begin
            csSync <= 2'h3;
            sclkSync <= 2'h0;
            mosiSync <= 2'h0;
            csLast <= 1'b1;
            sclkLast <= 1'b0;
        end else begin
            csSync <= {csSync[0], link.csN};
            sclkSync <= {sclkSync[0], link.sclk};
            mosiSync <= {mosiSync[0], link.mosi};
            csLast <= csSync[1];
            sclkLast <= sclkSync[1];
        end
    end
    logic selected, riseEdge, fallEdge, frameEnd;
    assign selected = !csSync[1];
    assign riseEdge = selected && sclkSync[1] && !sclkLast;
    assign fallEdge = selected && !sclkSync[1] && sclkLast;
    assign frameEnd = csSync[1] && !csLast;
    // ------------------------------------------------------------
    // receive: opcode and up to two data bytes
    // ------------------------------------------------------------
    logic [4:0] bitCount;
    logic [7:0] shiftIn, opcode, data1, data2;
    logic [7:0] nextByte;
    assign nextByte = {shiftIn[6:0], mosiSync[1]};
    always_ff @(posedge clk) begin
        if (rst || frameEnd) begin
            bitCount <= 5'd0;
            shiftIn <= 8'h00;
        end else if (riseEdge) begin
            shiftIn <= nextByte; // R6
            if (bitCount != BITS_TWO_DATA) bitCount <= bitCount + 5'd1;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            opcode <= 8'h00;
            data1 <= 8'h00;
            data2 <= 8'h00;
        end else if (riseEdge) begin
            if (bitCount == BITS_OPCODE - 5'd1) opcode <= nextByte;
            if (bitCount == BITS_ONE_DATA - 5'd1) data1 <= nextByte;
            if (bitCount == BITS_TWO_DATA - 5'd1) data2 <= nextByte;
        end
    end
    logic endOp, endOne, endTwo;
    assign endOp = frameEnd && bitCount == BITS_OPCODE;
    assign endOne = frameEnd && bitCount == BITS_ONE_DATA;
    assign endTwo = frameEnd && bitCount == BITS_TWO_DATA;
    // ------------------------------------------------------------
    // status storage
    // ------------------------------------------------------------
    logic [7:0] nv1, nv2, nv3, sr1, sr2, sr3;
    logic volatileArmed, cycleBusy;
    logic [15:0] cycleCount;
    logic [2:0] pendSel;
    logic [7:0] pend1, pend2;
    // keeps old bits outside mask; otp bits only ever set
    function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] val,
                                         input logic [7:0] mask, input logic [7:0] otp);
        merge = (old & ~mask) | (val & mask) | (old & otp); // R9 R10
    endfunction
    logic [7:0] sr2Mask;
    assign sr2Mask = fourLineCommandMode ? (SR2_WRITE_MASK & ~SR2_QUAD_MASK) : SR2_WRITE_MASK; // R16
    logic isStatusWrite, writeLegal, volatileWrite, nvStart;
    logic [2:0] writeSel;
    logic [7:0] writeA, writeB;
    always_comb begin
        writeSel = 3'b000;
        writeA = data1;
        writeB = data2;
        if (opcode == OP_WRITE_SR1 && endTwo) begin
            writeSel = 3'b011; // R17
        end else if (endOne) begin
            unique case (opcode)
                OP_WRITE_SR1: writeSel = 3'b001; // R17
                OP_WRITE_SR2: begin
                    writeSel = 3'b010;
                    writeB = data1;
                end
                OP_WRITE_SR3: writeSel = 3'b100;
                default: writeSel = 3'b000;
            endcase
        end
    end
    assign isStatusWrite = writeSel != 3'b000;
    assign writeLegal = isStatusWrite && !busy; // R7
    assign volatileWrite = writeLegal && volatileArmed; // R3 R12
    assign nvStart = writeLegal && !volatileArmed && writeEnableLatch; // R11 R24
    logic upperWrite;
    assign upperWrite = endOne && opcode == OP_WRITE_UPPER && !busy && writeEnableLatch; // R20 R24
    // ------------------------------------------------------------
    // nonvolatile write cycle
    // ------------------------------------------------------------
    logic cycleDone;
    assign cycleDone = cycleBusy && cycleCount == 16'(NV_CYCLES - 1);
    always_ff @(posedge clk) begin
        if (rst || deviceReset) begin
            cycleBusy <= 1'b0;
            cycleCount <= 16'h0000;
            pendSel <= 3'b000;
            pend1 <= 8'h00;
            pend2 <= 8'h00;
        end else if (nvStart) begin
            cycleBusy <= 1'b1; // R14
            cycleCount <= 16'h0000;
            pendSel <= writeSel;
            pend1 <= writeA;
            pend2 <= writeB;
        end else if (cycleDone) begin
            cycleBusy <= 1'b0; // R14
        end else if (cycleBusy) begin
            cycleCount <= cycleCount + 16'h0001;
        end
    end
    assign busy = cycleBusy || arrayBusy;
    always_ff @(posedge clk) begin
        if (rst) begin
            nv1 <= SR1_INIT;
            nv2 <= SR2_INIT;
            nv3 <= SR3_INIT;
        end else if (cycleDone) begin
            if (pendSel[0]) nv1 <= merge(nv1, pend1, SR1_WRITE_MASK, 8'h00);
            if (pendSel[1]) nv2 <= merge(nv2, pend2, sr2Mask, SR2_LOCK_MASK); // R10
            if (pendSel[2]) nv3 <= merge(nv3, pend1, SR3_WRITE_MASK, 8'h00);
        end
    end
    // live copies: volatile writes land at once, reset reloads
    always_ff @(posedge clk) begin
        if (rst) begin
            sr1 <= SR1_INIT;
            sr2 <= SR2_INIT;
            sr3 <= SR3_INIT;
        end else if (deviceReset) begin
            sr1 <= nv1; // R13
            sr2 <= nv2;
            sr3 <= nv3;
        end else if (volatileWrite) begin
            if (writeSel[0]) sr1 <= merge(sr1, writeA, SR1_WRITE_MASK, 8'h00); // R15
            if (writeSel[1]) sr2 <= merge(sr2, writeB, sr2Mask, SR2_LOCK_MASK | SR2_PROTECT_HIGH_MASK); // R12
            if (writeSel[2]) sr3 <= merge(sr3, writeA, SR3_WRITE_MASK, 8'h00);
        end else if (cycleDone) begin
            if (pendSel[0]) sr1 <= merge(nv1, pend1, SR1_WRITE_MASK, 8'h00);
            if (pendSel[1]) sr2 <= merge(nv2, pend2, sr2Mask, SR2_LOCK_MASK);
            if (pendSel[2]) sr3 <= merge(nv3, pend1, SR3_WRITE_MASK, 8'h00);
        end
    end
    assign quadEnable = sr2[SR2_QUAD_BIT];
    // ------------------------------------------------------------
    // latch, volatile arm, address mode, upper byte
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst || deviceReset || cycleDone || programDone || upperWrite) begin
            writeEnableLatch <= 1'b0; // R5 R14
        end else if (endOp && opcode == OP_WRITE_ENABLE) begin
            writeEnableLatch <= 1'b1; // R1 R2
        end else if (endOp && opcode == OP_WRITE_DISABLE) begin
            writeEnableLatch <= 1'b0; // R4
        end
    end
    always_ff @(posedge clk) begin
        if (rst || deviceReset) volatileArmed <= 1'b0;
        else if (frameEnd) volatileArmed <= endOp && opcode == OP_VOLATILE_ENABLE; // R3
    end
    always_ff @(posedge clk) begin
        if (rst || deviceReset) addressSizeFlag <= 1'b0;
        else if (endOp && opcode == OP_ENTER_4BYTE) addressSizeFlag <= 1'b1; // R23
        else if (endOp && opcode == OP_EXIT_4BYTE) addressSizeFlag <= 1'b0;
    end
    always_ff @(posedge clk) begin
        if (rst || deviceReset) upperAddressByte <= UPPER_RESET; // R21
        else if (upperWrite) upperAddressByte <= data1; // R20
        else if (addrTopValid && addressSizeFlag) upperAddressByte <= addrTopByte; // R19
    end
    // ------------------------------------------------------------
    // transmit: selected byte repeats until select rises
    // ------------------------------------------------------------
    logic [7:0] liveByte, snap;
    logic [2:0] outCount;
    logic reading;
    always_comb begin
        unique case (opcode)
            OP_READ_SR1: liveByte = {sr1[7:2], writeEnableLatch, busy}; // R6
            OP_READ_SR2: liveByte = sr2;
            OP_READ_SR3: liveByte = {sr3[7:1], addressSizeFlag};
            OP_READ_UPPER: liveByte = upperAddressByte; // R18
            default: liveByte = 8'h00;
        endcase
    end
    assign reading = bitCount >= BITS_OPCODE && (opcode == OP_READ_SR1 || opcode == OP_READ_SR2
                     || opcode == OP_READ_SR3 || opcode == OP_READ_UPPER); // R7
    always_ff @(posedge clk) begin
        if (rst || frameEnd) begin
            outCount <= 3'd0;
            snap <= 8'h00;
            link.miso <= 1'b0;
        end else if (fallEdge && reading) begin
            outCount <= outCount + 3'd1; // R8
            if (outCount == 3'd0) begin
                snap <= liveByte; // fresh byte each pass so busy polling tracks
                link.miso <= liveByte[7];
            end else begin
                link.miso <= snap[3'd7 - outCount]; // R6
            end
        end
    end
endmodule

// ===== rtl/flash_cmd_host.sv
// Purpose: serial host that frames one flash command per software request
// Assumes: Avalon-MM slave with waitrequest, one wait cycle per access
// Notes: serial clock derived from clk by a divider
`timescale 1ns/100ps
module flash_cmd_host
    import flash_cmd_pkg::*;
#(
    parameter int HALF_CYCLES = SCLK_HALF_CYCLES * 2
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register bus
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // serial link
    flash_link_if.host link
);
    typedef enum {IDLE, LEAD, LOW, HIGH, TRAIL} state_t;
    state_t state;
    logic ack, linkBusy;
    logic [7:0] opcode;
    logic [1:0] txBytes, rxBytes;
    logic [15:0] txData, rxData, rxShift;
    logic [23:0] frame;
    logic [5:0] bitsLeft;
    logic [7:0] timer;
    logic [1:0] misoSync;
    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    assign waitrequest = (read || write) && !ack;
    assign linkBusy = state != IDLE;
    always_ff @(posedge clk) begin
        if (rst) begin
            ack <= 1'b0;
        end else begin
            ack <= (read || write) && !ack;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            readdata <= 32'h0000_0000;
        end else if (read && !ack) begin
            unique case (address)
                REG_CONTROL: readdata <= {20'h00000, rxBytes, txBytes, opcode};
                REG_TX_DATA: readdata <= {16'h0000, txData};
                REG_RX_DATA: readdata <= {16'h0000, rxData};
                REG_STATUS: readdata <= {31'h00000000, linkBusy};
                default: readdata <= 32'h0000_0000;
            endcase
        end
    end
    logic start;
    assign start = write && ack && address == REG_CONTROL && !linkBusy;
    always_ff @(posedge clk) begin
        if (rst) begin
            opcode <= 8'h00;
            txBytes <= 2'd0;
            rxBytes <= 2'd0;
            txData <= 16'h0000;
        end else if (write && ack && !linkBusy) begin
            if (address == REG_CONTROL) begin
                opcode <= writedata[7:0];
                txBytes <= writedata[CTRL_TX_LSB +: 2];
                rxBytes <= writedata[CTRL_RX_LSB +: 2];
            end else if (address == REG_TX_DATA) begin
                txData <= writedata[15:0];
            end
        end
    end
    // ------------------------------------------------------------
    // serial engine
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            misoSync <= 2'b00;
        end else begin
            misoSync <= {misoSync[0], link.miso};
        end
    end
    logic timeUp;
    assign timeUp = timer == 8'(HALF_CYCLES - 1);
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= IDLE;
            timer <= 8'h00;
            frame <= 24'h000000;
            bitsLeft <= 6'd0;
            rxShift <= 16'h0000;
            rxData <= 16'h0000;
            link.csN <= 1'b1;
            link.sclk <= 1'b0;
            link.mosi <= 1'b0;
        end else begin
            timer <= timeUp ? 8'h00 : timer + 8'h01;
            unique case (state)
                IDLE: begin
                    timer <= 8'h00;
                    if (start) begin
                        // data bytes follow opcode, first byte in txData[15:8]
                        frame <= writedata[CTRL_TX_LSB +: 2] == 2'd1 ? {writedata[7:0], txData[15:8], 8'h00}
                                                 : {writedata[7:0], txData};
                        bitsLeft <= 6'(8 * (1 + int'(writedata[CTRL_TX_LSB +: 2])
                                        + int'(writedata[CTRL_RX_LSB +: 2])));
                        link.csN <= 1'b0;
                        state <= LEAD;
                    end
                end
                LEAD, LOW: begin
                    if (state == LEAD || timeUp) begin
                        link.mosi <= frame[23];
                        frame <= {frame[22:0], 1'b0};
                        state <= HIGH;
                        timer <= 8'h00;
                    end
                end
                HIGH: begin
                    if (timeUp) begin
                        link.sclk <= ~link.sclk;
                        if (link.sclk) begin
                            bitsLeft <= bitsLeft - 6'd1;
                            state <= bitsLeft == 6'd1 ? TRAIL : LOW;
                            if (bitsLeft == 6'd1) begin
                                timer <= 8'h00;
                            end else begin
                                link.mosi <= frame[23];
                                frame <= {frame[22:0], 1'b0};
                                state <= HIGH;
                            end
                        end else begin
                            rxShift <= {rxShift[14:0], misoSync[1]};
                        end
                    end
                end
                TRAIL: begin
                    if (timeUp) begin
                        link.csN <= 1'b1;
                        rxData <= rxShift;
                        state <= IDLE;
                    end
                end
            endcase
        end
    end
endmodule

// ===== rtl/flash_cmd_pkg.sv
// Purpose: shared constants for the serial flash status / upper address command pair
// Assumes: single-line serial framing, MSB first
// Notes: masks select the bits that a status write may change
package flash_cmd_pkg;
    // ------------------------------------------------------------
    // instruction codes
    // ------------------------------------------------------------
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_VOLATILE_ENABLE = 8'h50;
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OP_READ_SR1 = 8'h05;
    localparam logic [7:0] OP_READ_SR2 = 8'h35;
    localparam logic [7:0] OP_READ_SR3 = 8'h15;
    localparam logic [7:0] OP_WRITE_SR1 = 8'h01;
    localparam logic [7:0] OP_WRITE_SR2 = 8'h31;
    localparam logic [7:0] OP_WRITE_SR3 = 8'h11;
    localparam logic [7:0] OP_READ_UPPER = 8'hc8;
    localparam logic [7:0] OP_WRITE_UPPER = 8'hc5;
    localparam logic [7:0] OP_ENTER_4BYTE = 8'hb7;
    localparam logic [7:0] OP_EXIT_4BYTE = 8'he9;
    // ------------------------------------------------------------
    // status layout
    // ------------------------------------------------------------
    // sr1: 7 protect_lock_bit_low, 6 sector_granularity_select, 5 top_bottom_select,
    //      4:2 block_protect_field, 1 write_enable_latch, 0 busy
    // sr2: 7 suspend (ro), 6 protect_complement, 5:3 security_lock_bits, 2 reserved, 1 quad_enable,
    //      0 protect_lock_bit_high
    // sr3: 7 hold/reset select, 6 drive_strength_high, 5 drive_strength_low, 4 dummy_config_high,
    //      3 dummy_config_low, 0 address_size_flag (ro)
    localparam logic [7:0] SR1_WRITE_MASK = 8'hfc;
    localparam logic [7:0] SR2_WRITE_MASK = 8'h7b;
    localparam logic [7:0] SR3_WRITE_MASK = 8'hf8;
    localparam logic [7:0] SR2_LOCK_MASK = 8'h38;
    localparam logic [7:0] SR2_PROTECT_HIGH_MASK = 8'h01;
    localparam logic [7:0] SR2_QUAD_MASK = 8'h02;
    localparam int SR2_QUAD_BIT = 1;
    localparam logic [7:0] SR_RESET = 8'h00;
    localparam logic [7:0] UPPER_RESET = 8'h00;
    // ------------------------------------------------------------
    // frame lengths in bits
    // ------------------------------------------------------------
    localparam logic [4:0] BITS_OPCODE = 5'd8;
    localparam logic [4:0] BITS_ONE_DATA = 5'd16;
    localparam logic [4:0] BITS_TWO_DATA = 5'd24;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int NV_WRITE_TIME_NS = 10000;
    localparam int NV_WRITE_CYCLES = (NV_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SCLK_HALF_TIME_NS = 400;
    localparam int SCLK_HALF_CYCLES = (SCLK_HALF_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // ------------------------------------------------------------
    // host register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [3:0] REG_CONTROL = 4'h0;
    localparam logic [3:0] REG_TX_DATA = 4'h4;
    localparam logic [3:0] REG_RX_DATA = 4'h8;
    localparam logic [3:0] REG_STATUS = 4'hc;
    localparam int CTRL_TX_LSB = 8;
    localparam int CTRL_RX_LSB = 10;
endpackage

// ===== rtl/flash_link_if.sv
// Purpose: serial link between flash command host and device
// Assumes: host drives select and serial clock
// Notes: separate data lines, no shared pin
`timescale 1ns/100ps
interface flash_link_if;
    logic csN;
    logic sclk;
    logic mosi;
    logic miso;
    modport device(input csN, input sclk, input mosi, output miso);
    modport host(output csN, output sclk, output mosi, input miso);
endinterface

// ===== verif/flash_cmd_chk.sv
// Purpose: link and state checks for the host/device pair
// Assumes: device acts a few clk after select rises
// Notes: watches the interface and device side outputs
`timescale 1ns/100ps
module flash_cmd_chk (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // link
    input wire logic csN,
    input wire logic sclk,
    // device state
    input wire logic writeEnableLatch,
    input wire logic busy,
    input wire logic addressSizeFlag,
    input wire logic [7:0] upperAddressByte
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // write cycle lasts at least a few clk
    sequence busyRun;
        busy [*8];
    endsequence
    chk_sclk_framed: assert property ($changed(sclk) |-> !csN)
        else $error("serial clock moved outside a frame");
    chk_latch_set_framed: assert property ($rose(writeEnableLatch) |-> csN)
        else $error("latch set inside a frame");
    chk_latch_clear_framed: assert property ($fell(writeEnableLatch) |-> csN)
        else $error("latch cleared inside a frame");
    chk_busy_after_frame: assert property ($rose(busy) |-> csN)
        else $error("busy rose while selected");
    chk_busy_holds: assert property ($rose(busy) |-> busyRun)
        else $error("write cycle too short");
    chk_busy_end_latch: assert property ($fell(busy) |-> !writeEnableLatch)
        else $error("latch still set after write cycle");
    chk_upper_framed: assert property ($changed(upperAddressByte) |-> csN)
        else $error("upper byte changed inside a frame");
    chk_mode_framed: assert property ($changed(addressSizeFlag) |-> csN)
        else $error("address mode changed inside a frame");
endmodule

// ===== verif/flash_status_and_ext_addr_cmds_test.sv
// Purpose: bench for the flash command host and device pair
// Assumes: host answers with one wait cycle
// Notes: serial clock shortened, write cycle lengthened
`timescale 1ns/100ps
module flash_status_and_ext_addr_cmds_test;
    import flash_cmd_pkg::*;
    logic clk = 0, rst = 1, read = 0, write = 0, devRst = 0, fourLine = 0, topValid = 0, progDone = 0, arrBusy = 0;
    logic [3:0] address = 4'h0;
    logic [31:0] writedata = 32'h0, readdata, q;
    logic [15:0] rx;
    logic [7:0] topByte = 8'h0, upper;
    logic waitrequest, write_enable_latch, busy, address_size_flag, qe;
    int nMismatch = 0, nTests = 0;
    flash_link_if link();
    always #25 clk = ~clk;
    flash_cmd_host #(.HALF_CYCLES(8)) u_flash_cmd_host(.clk(clk), .rst(rst), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .link(link));
    flash_cmd_device #(.NV_CYCLES(400)) u_flash_cmd_device(.clk(clk), .rst(rst), .link(link),
        .deviceReset(devRst), .arrayBusy(arrBusy), .programDone(progDone), .fourLineCommandMode(fourLine),
        .addrTopValid(topValid), .addrTopByte(topByte), .writeEnableLatch(write_enable_latch), .busy(busy),
        .addressSizeFlag(address_size_flag), .upperAddressByte(upper), .quadEnable(qe));
    flash_cmd_chk u_flash_cmd_chk(.clk(clk), .rst(rst), .csN(link.csN), .sclk(link.sclk),
        .writeEnableLatch(write_enable_latch), .busy(busy), .addressSizeFlag(address_size_flag), .upperAddressByte(upper));
    task chk(input logic [15:0] s, input logic [15:0] e);
        nTests++;
        if (s !== e) begin
            nMismatch++;
            $display("BAD %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task bus(input logic [3:0] a, input logic w, input logic [31:0] d);
        address <= a;
        write <= w;
        read <= !w;
        writedata <= d;
        @(posedge clk);
        while (waitrequest !== 1'b0) @(posedge clk);
        q = readdata;
        write <= 1'b0;
        read <= 1'b0;
        @(posedge clk);
    endtask
    // one frame, then poll until the host is idle
    task cmd(input logic [7:0] op, input logic [15:0] d, input logic [1:0] nt, input logic [1:0] nr);
        bus(REG_TX_DATA, 1'b1, {16'h0, d});
        bus(REG_CONTROL, 1'b1, {20'h0, nr, nt, op});
        q = 32'h1;
        while (q[0] !== 1'b0) bus(REG_STATUS, 1'b0, 32'h0);
        repeat (8) @(posedge clk);
        bus(REG_RX_DATA, 1'b0, 32'h0);
        rx = q[15:0];
    endtask
    task rchk(input logic [7:0] op, input logic [7:0] e);
        cmd(op, 16'h0, 2'd0, 2'd1);
        chk({8'h0, rx[7:0]}, {8'h0, e});
    endtask
    task complete_run;
        $display("comparisons %0d mismatches %0d", nTests, nMismatch);
        if (nMismatch == 0 && nTests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge clk);
        nMismatch++;
        complete_run;
    end
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        rchk(OP_READ_SR1, 8'h00);
        rchk(OP_READ_UPPER, 8'h00);
        cmd(OP_WRITE_ENABLE, 16'h0, 2'd0, 2'd0);
        cmd(OP_READ_SR1, 16'h0, 2'd0, 2'd2);
        chk(rx, 16'h0202);
        cmd(OP_WRITE_DISABLE, 16'h0, 2'd0, 2'd0);
        rchk(OP_READ_SR1, 8'h00);
        cmd(OP_WRITE_ENABLE, 16'h0, 2'd0, 2'd0);
        progDone <= 1'b1;
        @(posedge clk);
        progDone <= 1'b0;
        rchk(OP_READ_SR1, 8'h00);
        cmd(OP_WRITE_SR1, 16'hffff, 2'd2, 2'd0);
        rchk(OP_READ_SR1, 8'h00);
        cmd(OP_WRITE_ENABLE, 16'h0, 2'd0, 2'd0);
        cmd(OP_WRITE_SR1, 16'hffff, 2'd2, 2'd0);
        rchk(OP_READ_SR1, 8'h03);
        repeat (400) @(posedge clk);
        rchk(OP_READ_SR1, SR1_WRITE_MASK);
        rchk(OP_READ_SR2, SR2_WRITE_MASK);
        arrBusy <= 1'b1;
        cmd(OP_VOLATILE_ENABLE, 16'h0, 2'd0, 2'd0);
        cmd(OP_WRITE_SR1, 16'h0000, 2'd1, 2'd0);
        rchk(OP_READ_SR1, 8'hfd);
        arrBusy <= 1'b0;
        fourLine <= 1'b1;
        cmd(OP_VOLATILE_ENABLE, 16'h0, 2'd0, 2'd0);
        cmd(OP_WRITE_SR2, 16'h0000, 2'd1, 2'd0);
        rchk(OP_READ_SR2, 8'h3b);
        chk({15'h0, qe}, 16'h0001);
        rchk(OP_READ_SR1, SR1_WRITE_MASK);
        fourLine <= 1'b0;
        cmd(OP_VOLATILE_ENABLE, 16'h0, 2'd0, 2'd0);
        cmd(OP_WRITE_SR1, 16'h2400, 2'd1, 2'd0);
        rchk(OP_READ_SR1, 8'h24);
        rchk(OP_READ_SR2, 8'h3b);
        cmd(OP_VOLATILE_ENABLE, 16'h0, 2'd0, 2'd0);
        cmd(OP_WRITE_SR3, 16'hff00, 2'd1, 2'd0);
        rchk(OP_READ_SR3, SR3_WRITE_MASK);
        cmd(OP_WRITE_UPPER, 16'h5a00, 2'd1, 2'd0);
        rchk(OP_READ_UPPER, 8'h00);
        cmd(OP_WRITE_ENABLE, 16'h0, 2'd0, 2'd0);
        cmd(OP_WRITE_UPPER, 16'h5a00, 2'd1, 2'd0);
        rchk(OP_READ_UPPER, 8'h5a);
        cmd(OP_ENTER_4BYTE, 16'h0, 2'd0, 2'd0);
        rchk(OP_READ_SR3, 8'hf9);
        topByte <= 8'ha5;
        topValid <= 1'b1;
        @(posedge clk);
        topValid <= 1'b0;
        @(posedge clk);
        chk({8'h0, upper}, 16'h00a5);
        cmd(OP_EXIT_4BYTE, 16'h0, 2'd0, 2'd0);
        topByte <= 8'h3c;
        topValid <= 1'b1;
        @(posedge clk);
        topValid <= 1'b0;
        rchk(OP_READ_UPPER, 8'ha5);
        devRst <= 1'b1;
        @(posedge clk);
        devRst <= 1'b0;
        repeat (2) @(posedge clk);
        rchk(OP_READ_SR2, SR2_WRITE_MASK);
        rchk(OP_READ_UPPER, 8'h00);
        rchk(OP_READ_SR3, 8'h00);
        complete_run;
    end
endmodule
